// ---- hw/fcb_pkg.sv ----
// constants and types shared by the fault memory and blink display
package fcb_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_MS = 100; // display and pedal timing base
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int LONG_ON_MS = 600;
  localparam int SHORT_ON_MS = 300;
  localparam int DIGIT_GAP_MS = 1000;
  localparam int CODE_GAP_MS = 1800;
  localparam int WAIT_MS = 3000;
  localparam int ENTRY_MS = 5000;
  localparam int ERASE_MS = 10000;
  localparam logic [7:0] LONG_ON_T = 8'(LONG_ON_MS / TICK_MS);
  localparam logic [7:0] SHORT_ON_T = 8'(SHORT_ON_MS / TICK_MS);
  localparam logic [7:0] DIGIT_GAP_T = 8'(DIGIT_GAP_MS / TICK_MS);
  localparam logic [7:0] CODE_GAP_T = 8'(CODE_GAP_MS / TICK_MS);
  localparam logic [7:0] WAIT_T = 8'(WAIT_MS / TICK_MS);
  localparam logic [7:0] ENTRY_T = 8'(ENTRY_MS / TICK_MS);
  localparam logic [7:0] ERASE_T = 8'(ERASE_MS / TICK_MS);
  localparam logic [2:0] ENTRY_PRESSES = 3'h5;
  localparam logic [3:0] ZERO_FLASHES = 4'hA;
  localparam logic [3:0] LETTER_A = 4'hA;
  localparam logic [3:0] LETTER_FLASHES = 4'hB;
  localparam logic [1:0] LAMP_OFF_COUNT = 2'h3;
  localparam logic [6:0] HIDE_ORD = 7'h28;
  localparam logic [6:0] HIDE_MIS = 7'h50;
  localparam logic [15:0] SPEED_TOL = 16'h0177; // 375 rpm
  localparam logic [15:0] NO_FAULT_CODE = 16'h0000;
  typedef enum logic [3:0] {
    FCB_IDLE = 4'b0001,
    FCB_ON = 4'b0010,
    FCB_OFF = 4'b0100,
    FCB_GAP = 4'b1000
  } fcb_blink_t;
endpackage : fcb_pkg

// ---- hw/fcb_tick.sv ----
// divider giving a one-cycle tick at the display time base
`timescale 1ns/1ps
`default_nettype none
module fcb_tick #(
  parameter int CYCLES = fcb_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  logic [31:0] cnt_reg;

  // free-running count, pulse on wrap
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_reg == 32'(CYCLES - 1)) begin
      cnt_reg <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule : fcb_tick
`default_nettype wire

// ---- hw/fcb_top.sv ----
// fault memory, trip counters, lamp control and blink-code display
`timescale 1ns/1ps
`default_nettype none
module fcb_top #(
  parameter int N = 4,
  parameter int TICK_CYCLES = fcb_pkg::TICK_CYC,
  parameter logic [N-1:0] MISFIRE_CLASS = '0,
  parameter logic [16*N-1:0] CODES = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ignition_on,
  input wire logic pedal_pressed,
  input wire logic trip_end,
  input wire logic all_monitors_run,
  input wire logic [N-1:0] fault_detect,
  input wire logic [N-1:0] fault_pass,
  input wire logic [15:0] engine_speed,
  input wire logic [15:0] engine_load,
  output logic fault_lamp,
  output logic self_diag_display_mode,
  output logic [N-1:0] confirmed_fault_code,
  output logic [N-1:0] first_trip_fault_code,
  output logic [N-1:0] confirmed_visible,
  output logic erase_done
);
  logic tick;
  logic [N-1:0] trip_seen_reg;
  logic [N-1:0] ft_snap_valid_reg;
  logic [15:0] snap_speed_reg [N];
  logic [15:0] snap_load_reg [N];
  logic [6:0] hide_cnt_reg [N];
  logic [1:0] off_cnt_reg;
  logic any_fault;
  logic erase_pulse;
  logic [N-1:0] shown;

  fcb_tick #(.CYCLES(TICK_CYCLES)) u_tick (.clk(clk), .rst_n(rst_n), .tick(tick));

  assign any_fault = |fault_detect;

  // similar-condition test against the stored snapshot
  function automatic logic similar(input logic [15:0] spd, input logic [15:0] ld,
                                   input logic [15:0] s_spd, input logic [15:0] s_ld);
    logic [16:0] d;
    logic [19:0] l10;
    logic [19:0] tol;
    d = (spd > s_spd) ? {1'b0, spd - s_spd} : {1'b0, s_spd - spd};
    l10 = (ld > s_ld) ? 20'(ld - s_ld) * 20'hA : 20'(s_ld - ld) * 20'hA;
    tol = {4'h0, s_ld};
    similar = (d <= {1'b0, fcb_pkg::SPEED_TOL}) && (l10 <= tol);
  endfunction : similar

  // per-fault code stores; erase dominates, detection beats clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      confirmed_fault_code <= '0;
      first_trip_fault_code <= '0;
      ft_snap_valid_reg <= '0;
      trip_seen_reg <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (erase_pulse) begin
          confirmed_fault_code[i] <= 1'b0;
          first_trip_fault_code[i] <= 1'b0;
          ft_snap_valid_reg[i] <= 1'b0;
          trip_seen_reg[i] <= 1'b0;
        end else if (fault_detect[i]) begin
          trip_seen_reg[i] <= 1'b1;
          if (first_trip_fault_code[i] && !trip_seen_reg[i]) begin
            confirmed_fault_code[i] <= 1'b1;
            if (MISFIRE_CLASS[i]) ft_snap_valid_reg[i] <= 1'b0;
          end else if (!first_trip_fault_code[i]) begin
            first_trip_fault_code[i] <= 1'b1;
            ft_snap_valid_reg[i] <= 1'b1;
          end
        end else if (fault_pass[i] && MISFIRE_CLASS[i]) begin
          first_trip_fault_code[i] <= 1'b0;
          ft_snap_valid_reg[i] <= 1'b0;
        end else if (trip_end) begin
          trip_seen_reg[i] <= 1'b0;
          if (!MISFIRE_CLASS[i] && all_monitors_run && !trip_seen_reg[i]) begin
            first_trip_fault_code[i] <= 1'b0;
            ft_snap_valid_reg[i] <= 1'b0;
          end
        end
      end
    end
  end

  // snapshot capture on detection
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (!rst_n) begin
        snap_speed_reg[i] <= 16'h0;
        snap_load_reg[i] <= 16'h0;
      end else if (fault_detect[i] && !(first_trip_fault_code[i] && trip_seen_reg[i])) begin
        snap_speed_reg[i] <= engine_speed;
        snap_load_reg[i] <= engine_load;
      end
    end
  end

  // expiry counters hide confirmed codes without forgetting them
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (!rst_n || erase_pulse || fault_detect[i]) begin
        hide_cnt_reg[i] <= 7'h0;
      end else if (trip_end && confirmed_fault_code[i] && !trip_seen_reg[i]) begin
        if (MISFIRE_CLASS[i]) begin
          if (similar(engine_speed, engine_load, snap_speed_reg[i], snap_load_reg[i]) &&
              hide_cnt_reg[i] < fcb_pkg::HIDE_MIS) hide_cnt_reg[i] <= hide_cnt_reg[i] + 7'h1;
        end else if (all_monitors_run && hide_cnt_reg[i] < fcb_pkg::HIDE_ORD) begin
          hide_cnt_reg[i] <= hide_cnt_reg[i] + 7'h1;
        end
      end
    end
  end

  // visibility of confirmed codes
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (!rst_n) confirmed_visible[i] <= 1'b0;
      else confirmed_visible[i] <= confirmed_fault_code[i] && !fault_detect[i] &&
          hide_cnt_reg[i] < (MISFIRE_CLASS[i] ? fcb_pkg::HIDE_MIS : fcb_pkg::HIDE_ORD) ||
          confirmed_fault_code[i] && fault_detect[i];
    end
  end

  // lamp-off counter: malfunction clears, clean full drive counts
  always_ff @(posedge clk) begin
    if (!rst_n || erase_pulse || any_fault) begin
      off_cnt_reg <= 2'h0;
    end else if (trip_end && all_monitors_run && !(|trip_seen_reg) && fault_lamp &&
                 off_cnt_reg != fcb_pkg::LAMP_OFF_COUNT) begin
      off_cnt_reg <= off_cnt_reg + 2'h1;
    end
  end

  // lamp: lit on confirm, off at count 3, blinking in display mode
  logic blink_lamp;
  logic warn_lamp_reg;
  always_ff @(posedge clk) begin
    if (!rst_n || erase_pulse) warn_lamp_reg <= 1'b0;
    else if (|(fault_detect & first_trip_fault_code & ~trip_seen_reg)) warn_lamp_reg <= 1'b1;
    else if (off_cnt_reg == fcb_pkg::LAMP_OFF_COUNT) warn_lamp_reg <= 1'b0;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) fault_lamp <= 1'b0;
    else fault_lamp <= self_diag_display_mode ? blink_lamp : warn_lamp_reg;
  end

  // mode entry and erase from the pedal, in 100 ms ticks
  logic [7:0] mtime_reg;
  logic [7:0] hold_reg;
  logic [2:0] press_reg;
  logic pedal_d_reg;
  logic armed_reg;
  always_ff @(posedge clk) begin
    if (!rst_n || !ignition_on) begin
      self_diag_display_mode <= 1'b0;
      mtime_reg <= 8'h0;
      press_reg <= 3'h0;
      armed_reg <= 1'b0;
      hold_reg <= 8'h0;
      pedal_d_reg <= 1'b0;
      erase_pulse <= 1'b0;
    end else begin
      pedal_d_reg <= pedal_pressed;
      erase_pulse <= 1'b0;
      if (tick && mtime_reg != 8'hFF) mtime_reg <= mtime_reg + 8'h1;
      if (!pedal_pressed) hold_reg <= 8'h0;
      else if (tick && hold_reg != 8'hFF) hold_reg <= hold_reg + 8'h1;
      if (!armed_reg && mtime_reg >= fcb_pkg::WAIT_T && !pedal_pressed) begin
        armed_reg <= 1'b1;
        mtime_reg <= 8'h0;
      end
      if (armed_reg && !self_diag_display_mode) begin
        if (pedal_d_reg && !pedal_pressed && mtime_reg <= fcb_pkg::ENTRY_T) begin
          press_reg <= press_reg + 3'h1;
          if (press_reg + 3'h1 == fcb_pkg::ENTRY_PRESSES) self_diag_display_mode <= 1'b1;
        end
      end
      if (self_diag_display_mode && tick && hold_reg == fcb_pkg::ERASE_T) begin
        erase_pulse <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) erase_done <= 1'b0;
    else erase_done <= erase_pulse;
  end

  // code list shown: confirmed and first-trip merged; only first-trip if lamp dark
  assign shown = warn_lamp_reg ? (confirmed_visible | first_trip_fault_code)
                               : first_trip_fault_code;

  // blink engine
  fcb_pkg::fcb_blink_t st_reg;
  logic [$clog2(N+1)-1:0] idx_reg;
  logic [1:0] dig_reg;
  logic [3:0] fl_reg;
  logic [7:0] t_reg;
  logic [15:0] code;
  logic [3:0] nib;
  logic [7:0] on_t;
  assign code = (idx_reg == N[$clog2(N+1)-1:0]) ? fcb_pkg::NO_FAULT_CODE
              : CODES[16*idx_reg +: 16];
  assign nib = code[4*(3-dig_reg) +: 4];
  assign on_t = (dig_reg == 2'h0) ? fcb_pkg::LONG_ON_T : fcb_pkg::SHORT_ON_T;

  function automatic logic [3:0] flashes(input logic [3:0] v);
    if (v == 4'h0) flashes = fcb_pkg::ZERO_FLASHES;
    else if (v == fcb_pkg::LETTER_A) flashes = fcb_pkg::LETTER_FLASHES;
    else flashes = v;
  endfunction : flashes

  // next shown code index after cur, or N meaning "0000" when nothing is shown
  function automatic logic [$clog2(N+1)-1:0] next_idx(input logic [$clog2(N+1)-1:0] cur,
                                                      input logic [N-1:0] m);
    next_idx = N[$clog2(N+1)-1:0];
    for (int k = N - 1; k >= 0; k--) begin
      if (m[k] && k > int'(cur)) next_idx = k[$clog2(N+1)-1:0];
    end
    if (next_idx == N[$clog2(N+1)-1:0]) begin
      for (int k = N - 1; k >= 0; k--) begin
        if (m[k]) next_idx = k[$clog2(N+1)-1:0]; // wrap
      end
    end
  endfunction : next_idx

  always_ff @(posedge clk) begin
    if (!rst_n || !self_diag_display_mode) begin
      st_reg <= fcb_pkg::FCB_IDLE;
      blink_lamp <= 1'b0;
      idx_reg <= N[$clog2(N+1)-1:0];
      dig_reg <= 2'h0;
      fl_reg <= 4'h0;
      t_reg <= 8'h0;
    end else if (tick) begin
      unique case (st_reg)
        fcb_pkg::FCB_IDLE: begin
          idx_reg <= next_idx(N[$clog2(N+1)-1:0], shown);
          dig_reg <= 2'h0;
          fl_reg <= 4'h0;
          t_reg <= 8'h1;
          blink_lamp <= 1'b1;
          st_reg <= fcb_pkg::FCB_ON;
        end
        fcb_pkg::FCB_ON: begin
          if (t_reg >= on_t) begin
            blink_lamp <= 1'b0;
            t_reg <= 8'h1;
            fl_reg <= fl_reg + 4'h1;
            if (fl_reg + 4'h1 >= flashes(nib)) st_reg <= fcb_pkg::FCB_GAP;
            else st_reg <= fcb_pkg::FCB_OFF;
          end else t_reg <= t_reg + 8'h1;
        end
        fcb_pkg::FCB_OFF: begin
          if (t_reg >= on_t) begin
            blink_lamp <= 1'b1;
            t_reg <= 8'h1;
            st_reg <= fcb_pkg::FCB_ON;
          end else t_reg <= t_reg + 8'h1;
        end
        fcb_pkg::FCB_GAP: begin
          // last digit waits the code gap, others the digit gap
          if (t_reg >= ((dig_reg == 2'h3) ? fcb_pkg::CODE_GAP_T : fcb_pkg::DIGIT_GAP_T)) begin
            t_reg <= 8'h1;
            fl_reg <= 4'h0;
            blink_lamp <= 1'b1;
            st_reg <= fcb_pkg::FCB_ON;
            dig_reg <= dig_reg + 2'h1;
            if (dig_reg == 2'h3) idx_reg <= next_idx(idx_reg, shown);
          end else t_reg <= t_reg + 8'h1;
        end
      endcase
    end
  end

  // checks
  property p_mode_off;
    @(posedge clk) disable iff (!rst_n) !ignition_on |=> !self_diag_display_mode;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("mode kept after ignition off");
  property p_cnt_clear;
    @(posedge clk) disable iff (!rst_n) any_fault |=> off_cnt_reg == 2'h0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("lamp-off counter not cleared");
  property p_lamp_off;
    @(posedge clk) disable iff (!rst_n)
      off_cnt_reg == fcb_pkg::LAMP_OFF_COUNT && !any_fault |=> !warn_lamp_reg;
  endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("lamp stayed on at count 3");
  property p_first;
    @(posedge clk) disable iff (!rst_n)
      fault_detect[0] && !erase_pulse |=> first_trip_fault_code[0] || confirmed_fault_code[0];
  endproperty
  a_first: assert property (p_first) else $error("first detection not stored");
  property p_only_ft;
    @(posedge clk) disable iff (!rst_n) !warn_lamp_reg |-> shown == first_trip_fault_code;
  endproperty
  a_only_ft: assert property (p_only_ft) else $error("confirmed code shown with dark lamp");
  property p_erase;
    @(posedge clk) disable iff (!rst_n) erase_pulse |=> confirmed_fault_code == '0;
  endproperty
  a_erase: assert property (p_erase) else $error("erase left codes");
  property p_lamp_mode;
    @(posedge clk) disable iff (!rst_n)
      !self_diag_display_mode ##1 !self_diag_display_mode |-> fault_lamp == $past(warn_lamp_reg);
  endproperty
  a_lamp_mode: assert property (p_lamp_mode) else $error("lamp not following warning");
  property p_long_on;
    @(posedge clk) disable iff (!rst_n)
      st_reg == fcb_pkg::FCB_ON && dig_reg == 2'h0 |-> t_reg <= fcb_pkg::LONG_ON_T;
  endproperty
  a_long_on: assert property (p_long_on) else $error("top digit on time exceeded");
  c_mode: cover property (@(posedge clk) $rose(self_diag_display_mode));
  c_erase: cover property (@(posedge clk) erase_pulse);
  c_gap: cover property (@(posedge clk) st_reg == fcb_pkg::FCB_GAP && dig_reg == 2'h3);
endmodule : fcb_top
`default_nettype wire

// ---- tb/fcb_panel_model.sv ----
// panel model: accelerator pedal switch and fault lamp observer
`timescale 1ns/1ps
`default_nettype none
module fcb_panel_model (
  input wire logic clk,
  input wire logic fault_lamp,
  output logic pedal_pressed
);
  // pedal starts released so the entry wait can run
  initial pedal_pressed = 1'b0;

  // moves to just after a rising edge, where the bench drives and samples
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : step

  // operator entry: pedal released for the wait, then five full strokes
  task automatic entry_strokes(input int wait_cyc, input int stroke_cyc);
    pedal_pressed = 1'b0;
    step(wait_cyc);
    repeat (5) begin
      pedal_pressed = 1'b1;
      step(stroke_cyc);
      pedal_pressed = 1'b0;
      step(stroke_cyc);
    end
  endtask : entry_strokes

  // long presses for entry and erase
  task automatic set_pedal(input logic v);
    pedal_pressed = v;
  endtask : set_pedal

  // length of the lamp run at level lvl; bounded so a stuck lamp cannot hang
  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (fault_lamp === lvl && n < 4000) begin
      n++;
      step(1);
    end
  endtask : run_len
endmodule : fcb_panel_model
`default_nettype wire

// ---- tb/tb_fcb_top.sv ----
// self-checking bench for the fault memory and blink-code display
`timescale 1ns/1ps
`default_nettype none
module tb_fcb_top;
  localparam int TK = 10; // short tick keeps the 10 s counts cheap
  localparam logic [15:0] SPD = 16'h0400;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ignition_on = 1'b1;
  logic pedal_pressed;
  logic trip_end = 1'b0;
  logic all_monitors_run = 1'b0;
  logic [3:0] fault_detect = 4'h0;
  logic [3:0] fault_pass = 4'h0;
  logic [15:0] engine_speed = SPD;
  logic [15:0] engine_load = 16'h0032;
  logic fault_lamp;
  logic self_diag_display_mode;
  logic [3:0] conf;
  logic [3:0] ftrip;
  logic [3:0] vis;
  logic erase_done;
  int fails = 0;
  int cmp_count = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // fault 3 is the misfire class; codes hold zero, letter and every digit
  fcb_top #(.N(4), .TICK_CYCLES(TK), .MISFIRE_CLASS(4'h8),
    .CODES({16'h0301, 16'h7890, 16'h3456, 16'h0A12})) uut (
    .clk(clk), .rst_n(rst_n), .ignition_on(ignition_on), .pedal_pressed(pedal_pressed),
    .trip_end(trip_end), .all_monitors_run(all_monitors_run), .fault_detect(fault_detect),
    .fault_pass(fault_pass), .engine_speed(engine_speed), .engine_load(engine_load),
    .fault_lamp(fault_lamp), .self_diag_display_mode(self_diag_display_mode),
    .confirmed_fault_code(conf), .first_trip_fault_code(ftrip),
    .confirmed_visible(vis), .erase_done(erase_done));
  fcb_panel_model pm (.clk(clk), .fault_lamp(fault_lamp), .pedal_pressed(pedal_pressed));

  // verdict and end of run
  task automatic complete_run();
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // a bounded wait that ran out ends the run
  task automatic bail(input logic ok);
    if (ok !== 1'b1) begin
      fails++;
      complete_run();
    end
  endtask : bail

  function automatic int cyc(input int ms);
    return ms / fcb_pkg::TICK_MS * TK;
  endfunction : cyc

  // stored codes in ascending fault order, wrapping round
  function automatic logic [15:0] nxt(input logic [15:0] c);
    return (c === 16'h0A12) ? 16'h3456 : (c === 16'h3456) ? 16'h7890 : 16'h0A12;
  endfunction : nxt

  task automatic detect(input int i);
    fault_detect[i] = 1'b1;
    pm.step(1);
    fault_detect = 4'h0;
    pm.step(2);
  endtask : detect

  task automatic trip(input logic amr);
    all_monitors_run = amr;
    trip_end = 1'b1;
    pm.step(1);
    trip_end = 1'b0;
    all_monitors_run = 1'b0;
    pm.step(3);
  endtask : trip

  // ignition cycle rearms entry; long press only if strokes alone did not do it
  task automatic enter_mode();
    int i;
    ignition_on = 1'b0;
    pm.step(4);
    ignition_on = 1'b1;
    pm.entry_strokes(cyc(3000) + 2 * TK, 3 * TK);
    for (i = 0; i < cyc(7000) && self_diag_display_mode !== 1'b1; i++) pm.step(1);
    if (self_diag_display_mode !== 1'b1) begin
      pm.set_pedal(1'b1);
      for (i = 0; i < cyc(12000) && self_diag_display_mode !== 1'b1; i++) pm.step(1);
      pm.set_pedal(1'b0);
    end
    pm.step(2);
    bail(self_diag_display_mode);
  endtask : enter_mode

  // only the gap between codes is this long, so its end starts a code
  task automatic sync();
    int n;
    int a;
    int b;
    b = 0;
    for (n = 0; n < 60 && b < cyc(1500); n++) begin
      pm.run_len(1'b1, a);
      pm.run_len(1'b0, b);
    end
    bail(b >= cyc(1500));
  endtask : sync

  // decodes one code from flash counts, timing every on and off run
  task automatic read_code(output logic [15:0] code);
    int d;
    int cnt;
    int on_len;
    int off_len;
    int on_exp;
    code = 16'h0000;
    for (d = 0; d < 4; d++) begin
      on_exp = (d == 0) ? cyc(600) : cyc(300);
      cnt = 0;
      off_len = on_exp;
      while (off_len == on_exp && cnt < 12) begin
        pm.run_len(1'b1, on_len);
        pm.run_len(1'b0, off_len);
        cnt++;
        check(on_len, on_exp);
      end
      check(off_len, (d == 3) ? cyc(1800) : cyc(1000));
      code = {code[11:0], (cnt == 10) ? 4'h0 : (cnt == 11) ? 4'hA : 4'(cnt)};
    end
  endtask : read_code

  task automatic sc_reset();
    check(32'({fault_lamp, self_diag_display_mode, erase_done}), 32'h0);
    check(32'({conf, ftrip, vis}), 32'h0);
  endtask : sc_reset

  // three first-trip codes, lamp dark, shown in order and repeated
  task automatic sc_first_trip_display();
    logic [15:0] c0;
    logic [15:0] c;
    logic [15:0] p;
    int k;
    detect(0);
    detect(1);
    detect(2);
    check(32'({ftrip, conf, fault_lamp}), 32'h0E0);
    enter_mode();
    sync();
    read_code(c0);
    check(32'(nxt(nxt(nxt(c0)))), 32'(c0));
    p = c0;
    for (k = 0; k < 3; k++) begin
      read_code(c);
      check(32'(c), 32'(nxt(p)));
      p = c;
    end
    ignition_on = 1'b0;
    pm.step(3);
    check(32'(self_diag_display_mode), 32'h0);
    ignition_on = 1'b1;
  endtask : sc_first_trip_display

  // two-trip confirmation, and a misfire pass clearing its first-trip code
  task automatic sc_confirm();
    trip(1'b0);
    detect(0);
    check(32'({conf[0], fault_lamp}), 32'h3);
    detect(3);
    // pass on every fault: only the misfire class clears at once
    fault_pass = 4'hF;
    pm.step(1);
    fault_pass = 4'h0;
    pm.step(2);
    check(32'(ftrip[3]), 32'h0);
    check(32'(ftrip), 32'h7);
    detect(3);
    trip(1'b0);
    detect(3);
    check(32'({conf, vis}), 32'h99);
  endtask : sc_confirm

  // qualifying drives: lamp-off count, expiry of both classes, similar-condition window
  task automatic sc_drives();
    int i;
    for (i = 1; i <= 85; i++) begin
      // drive 2 misses on speed by 1 rpm, 3 on load, 4 and 5 on both; the rest sit on the edges
      engine_speed = (i == 2) ? SPD + 16'h0178 : (i == 4) ? 16'hFFFF : (i == 5) ? 16'h0000
                   : SPD + 16'h0177;
      engine_load = (i == 3 || i == 5) ? 16'hFFFF : (i == 4) ? 16'h0000 : 16'h0037;
      if (i == 3) detect(1);
      trip(1'b1);
      if (i == 1) check(32'(ftrip[2]), 32'h0);
      if (i == 5) check(32'(fault_lamp), 32'h1);
      if (i == 6) check(32'(fault_lamp), 32'h0);
      if (i == 39) check(32'({conf[0], vis[0]}), 32'h3);
      if (i == 40) check(32'({conf[0], vis[0]}), 32'h2);
      if (i == 84) check(32'(vis[3]), 32'h1);
      if (i == 85) check(32'(vis[3]), 32'h0);
    end
  endtask : sc_drives

  // long press in display mode wipes the stores, then 0000 is shown
  task automatic sc_erase();
    int n;
    logic [15:0] c;
    enter_mode();
    pm.set_pedal(1'b1);
    for (n = 0; n < cyc(12000) && erase_done !== 1'b1; n++) pm.step(1);
    bail(erase_done);
    check(32'(n >= cyc(9900)), 32'h1);
    pm.step(1);
    check(32'({erase_done, conf, ftrip, vis}), 32'h0);
    pm.set_pedal(1'b0);
    sync();
    read_code(c);
    check(32'(c), 32'h0);
  endtask : sc_erase

  // reset for 8 cycles, then the scenarios in order
  initial begin
    pm.step(8);
    rst_n = 1'b1;
    pm.step(1);
    sc_reset();
    sc_first_trip_display();
    sc_confirm();
    sc_drives();
    sc_erase();
    complete_run();
  end
endmodule : tb_fcb_top
`default_nettype wire
